// ### core/dtd_cfg_regs.sv
`timescale 1ns/100ps
`include "dtd_consts.svh"
module dtd_cfg_regs
  import dtd_pkg::*;
#(
  parameter int LANES = 8,
  parameter int SAMPLE_W = 16,
  parameter int ERR_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_err_real,
  input wire logic i_err_imag,
  input wire logic [SAMPLE_W-1:0] i_sample,
  output logic [SAMPLE_W-1:0] o_sample,
  output logic o_checker_enable,
  output logic o_checker_poly_long,
  output logic o_checker_inv_real,
  output logic o_checker_inv_imag,
  output logic o_shuffle_msb,
  output logic o_middle_segment_shuffle,
  output logic o_shuffle_ddr,
  output dtd_zone_t o_zone,
  output logic [1:0] o_port_slew,
  output logic [1:0] o_port_strength,
  output logic o_rx_analog_master_off,
  output logic [LANES-1:0] o_rx_lane_off,
  output logic o_sync_request_buffer_off,
  output logic o_clock_recovery_logic_reset,
  output logic o_half_rate_recovery_enable,
  output dtd_div_t o_division_rate
);
  if (LANES != 8) begin : g_lanes_chk
    $error("dtd_cfg_regs: LANES must be 8");
  end
  if (SAMPLE_W != 16) begin : g_sample_w_chk
    $error("dtd_cfg_regs: SAMPLE_W must be 16");
  end
  if (ERR_W != 8) begin : g_err_w_chk
    $error("dtd_cfg_regs: ERR_W must be 8");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] chk_ctrl_reg;
  logic [7:0] const_hi_reg;
  logic [7:0] const_lo_reg;
  logic [7:0] digital_test_ctrl_reg;
  logic [7:0] shuffle_reg;
  logic [1:0] zone_reg;
  logic [3:0] drive_reg;
  logic rx_analog_master_powerdown_reg;
  logic [7:0] lane_pd_reg;
  logic [7:0] misc_pd_reg;
  logic cdr_rst_reg;
  logic [7:0] cdr_rate_reg;
  logic [ERR_W-1:0] cnt_real;
  logic [ERR_W-1:0] cnt_imag;

  function automatic logic hit(input logic [9:0] addr, input logic [9:0] ref_addr);
    hit = i_wr_en && (addr == ref_addr);
  endfunction : hit

  // ----------------------------------------
  // Checker control
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      chk_ctrl_reg <= `DTD_RST_CHK_CTRL;
    end else if (hit(i_addr, `DTD_ADDR_CHK_CTRL)) begin
      chk_ctrl_reg <= i_wdata & `DTD_CHK_CTRL_WMASK; // RULE_17
    end
  end

  dtd_err_counter #(
    .WIDTH(ERR_W)
  ) u_cnt_real (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_enable(chk_ctrl_reg[`DTD_BIT_CHK_EN]),
    .i_clear(chk_ctrl_reg[`DTD_BIT_CHK_CLR]),
    .i_error(i_err_real),
    .o_count(cnt_real)
  ); // RULE_01

  dtd_err_counter #(
    .WIDTH(ERR_W)
  ) u_cnt_imag (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_enable(chk_ctrl_reg[`DTD_BIT_CHK_EN]),
    .i_clear(chk_ctrl_reg[`DTD_BIT_CHK_CLR]),
    .i_error(i_err_imag),
    .o_count(cnt_imag)
  ); // RULE_02

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_checker_enable <= 1'b0;
      o_checker_poly_long <= 1'b0;
      o_checker_inv_real <= 1'b0;
      o_checker_inv_imag <= 1'b1;
    end else begin
      o_checker_enable <= chk_ctrl_reg[`DTD_BIT_CHK_EN];
      o_checker_poly_long <= chk_ctrl_reg[2];
      o_checker_inv_real <= chk_ctrl_reg[3];
      o_checker_inv_imag <= chk_ctrl_reg[4];
    end
  end

  // ----------------------------------------
  // Constant test source
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      const_hi_reg <= 8'h00;
      const_lo_reg <= 8'h00;
      digital_test_ctrl_reg <= 8'h00;
    end else begin
      if (hit(i_addr, `DTD_ADDR_CONST_HI)) begin
        const_hi_reg <= i_wdata;
      end
      if (hit(i_addr, `DTD_ADDR_CONST_LO)) begin
        const_lo_reg <= i_wdata;
      end
      if (hit(i_addr, `DTD_ADDR_DIGITAL_TEST_CTRL)) begin
        digital_test_ctrl_reg <= i_wdata & `DTD_DIGITAL_TEST_CTRL_WMASK; // RULE_17
      end
    end
  end

  dtd_sample_mux #(
    .WIDTH(SAMPLE_W)
  ) u_mux (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_const_en(digital_test_ctrl_reg[`DTD_BIT_CONST_EN]),
    .i_const_word({const_hi_reg, const_lo_reg}),
    .i_sample(i_sample),
    .o_sample(o_sample)
  ); // RULE_03

  // ----------------------------------------
  // Decode control
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      shuffle_reg <= `DTD_RST_SHUFFLE;
      zone_reg <= 2'h0;
    end else begin
      if (hit(i_addr, `DTD_ADDR_SHUFFLE)) begin
        shuffle_reg <= i_wdata;
      end
      if (hit(i_addr, `DTD_ADDR_ZONE)) begin
        zone_reg <= i_wdata[1:0]; // RULE_07
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_shuffle_msb <= 1'b0;
      o_middle_segment_shuffle <= 1'b0;
      o_shuffle_ddr <= 1'b0;
      o_zone <= DTD_ZONE_FIRST;
    end else begin
      o_shuffle_msb <= shuffle_reg[`DTD_BIT_SHUF_MSB]; // RULE_04
      o_middle_segment_shuffle <= shuffle_reg[`DTD_BIT_SHUF_MID]; // RULE_05
      o_shuffle_ddr <= shuffle_reg[`DTD_BIT_SHUF_DDR]; // RULE_06
      o_zone <= dtd_zone_t'(zone_reg); // RULE_07
    end
  end

  // ----------------------------------------
  // Port drive and power-down
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      drive_reg <= `DTD_RST_DRIVE;
      rx_analog_master_powerdown_reg <= `DTD_RST_RX_ANALOG_MASTER_POWERDOWN;
      lane_pd_reg <= 8'h00;
      misc_pd_reg <= 8'h00;
    end else begin
      if (hit(i_addr, `DTD_ADDR_DRIVE)) begin
        drive_reg <= i_wdata[3:0]; // RULE_08
      end
      if (hit(i_addr, `DTD_ADDR_RX_ANALOG_MASTER_POWERDOWN)) begin
        rx_analog_master_powerdown_reg <= i_wdata[0]; // RULE_09
      end
      if (hit(i_addr, `DTD_ADDR_LANE_PD)) begin
        lane_pd_reg <= i_wdata; // RULE_10
      end
      if (hit(i_addr, `DTD_ADDR_MISC_PD)) begin
        misc_pd_reg <= i_wdata & `DTD_MISC_PD_WMASK;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_port_slew <= 2'h3;
      o_port_strength <= 2'h3;
      o_rx_analog_master_off <= 1'b1;
      o_rx_lane_off <= '0;
      o_sync_request_buffer_off <= 1'b0;
    end else begin
      o_port_slew <= drive_reg[1:0]; // RULE_08
      o_port_strength <= drive_reg[3:2]; // RULE_08
      o_rx_analog_master_off <= rx_analog_master_powerdown_reg; // RULE_09
      for (int n = 0; n < LANES; n++) begin
        o_rx_lane_off[n] <= lane_pd_reg[n] | rx_analog_master_powerdown_reg; // RULE_11
      end
      o_sync_request_buffer_off <= misc_pd_reg[`DTD_BIT_SYNC_OFF];
    end
  end

  // ----------------------------------------
  // Clock recovery
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cdr_rst_reg <= `DTD_RST_CDR_RST;
      cdr_rate_reg <= `DTD_RST_CDR_RATE;
    end else begin
      if (hit(i_addr, `DTD_ADDR_CDR_RST)) begin
        cdr_rst_reg <= i_wdata[0]; // RULE_12
      end
      if (hit(i_addr, `DTD_ADDR_CDR_RATE)) begin
        cdr_rate_reg <= i_wdata & `DTD_CDR_RATE_WMASK; // RULE_13
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_clock_recovery_logic_reset <= 1'b1;
      o_half_rate_recovery_enable <= 1'b1;
      o_division_rate <= DTD_DIV_1;
    end else begin
      o_clock_recovery_logic_reset <= cdr_rst_reg; // RULE_12
      o_half_rate_recovery_enable <= cdr_rate_reg[`DTD_BIT_HALF_RATE]; // RULE_13
      o_division_rate <= dtd_div_t'(cdr_rate_reg[2:1]); // RULE_14 RULE_15
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd_en;
      if (i_rd_en) begin
        case (i_addr)
          `DTD_ADDR_CHK_CTRL: o_rdata <= chk_ctrl_reg;
          `DTD_ADDR_ERR_REAL: o_rdata <= cnt_real; // RULE_01
          `DTD_ADDR_ERR_IMAG: o_rdata <= cnt_imag; // RULE_02
          `DTD_ADDR_CONST_HI: o_rdata <= const_hi_reg;
          `DTD_ADDR_CONST_LO: o_rdata <= const_lo_reg;
          `DTD_ADDR_DIGITAL_TEST_CTRL: o_rdata <= digital_test_ctrl_reg; // RULE_17
          `DTD_ADDR_SHUFFLE: o_rdata <= shuffle_reg;
          `DTD_ADDR_ZONE: o_rdata <= {6'h00, zone_reg};
          `DTD_ADDR_DRIVE: o_rdata <= {4'h0, drive_reg};
          `DTD_ADDR_RX_ANALOG_MASTER_POWERDOWN: o_rdata <= {7'h00, rx_analog_master_powerdown_reg};
          `DTD_ADDR_LANE_PD: o_rdata <= lane_pd_reg;
          `DTD_ADDR_MISC_PD: o_rdata <= misc_pd_reg;
          `DTD_ADDR_CDR_RST: o_rdata <= {7'h00, cdr_rst_reg};
          `DTD_ADDR_CDR_RATE: o_rdata <= cdr_rate_reg;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : dtd_cfg_regs

// ### core/dtd_consts.svh
`ifndef DTD_CONSTS_SVH
`define DTD_CONSTS_SVH
// Behaviour
// [RULE_01] Real error count readable, 8 bits, resets zero
// [RULE_02] Imaginary error count readable, 8 bits, resets zero
// [RULE_03] Constant test enable substitutes 16-bit constant word
// [RULE_04] Bit 2 selects top segment shuffling
// [RULE_05] Bit 1 selects middle segment shuffling
// [RULE_06] Bit 0 selects double-rate segment shuffling
// [RULE_07] Zone code 00 first, 01 second zone
// [RULE_08] Drive field: slew low bits, strength high
// [RULE_09] Master power-down resets set, powers receiver off
// [RULE_10] Per-lane power-down mask, clear at reset
// [RULE_11] Mask bit n controls lane n
// [RULE_12] Recovery reset bit holds lane logic, resets set
// [RULE_13] Half-rate enable above 6 Gbps, defaults set
// [RULE_14] Division 00 above 3G, 01 to 3G
// [RULE_15] Division 10 for 750M to 1.5G
// [RULE_16] Counter-clear bit clears both error counters
// [RULE_17] Reserved bits read reset value, read-only ignore writes
// [RULE_18] Counters count when enabled, saturate at max

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DTD_ADDR_CHK_CTRL 10'h14b
`define DTD_ADDR_ERR_REAL 10'h14c
`define DTD_ADDR_ERR_IMAG 10'h14d
`define DTD_ADDR_CONST_HI 10'h14e
`define DTD_ADDR_CONST_LO 10'h14f
`define DTD_ADDR_DIGITAL_TEST_CTRL 10'h150
`define DTD_ADDR_SHUFFLE 10'h151
`define DTD_ADDR_ZONE 10'h152
`define DTD_ADDR_DRIVE 10'h1df
`define DTD_ADDR_RX_ANALOG_MASTER_POWERDOWN 10'h200
`define DTD_ADDR_LANE_PD 10'h201
`define DTD_ADDR_MISC_PD 10'h203
`define DTD_ADDR_CDR_RST 10'h206
`define DTD_ADDR_CDR_RATE 10'h230

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DTD_RST_CHK_CTRL 8'h10
`define DTD_RST_DRIVE 4'hf
`define DTD_RST_RX_ANALOG_MASTER_POWERDOWN 1'b1
`define DTD_RST_CDR_RST 1'b1
`define DTD_RST_CDR_RATE 8'h28
`define DTD_RST_SHUFFLE 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DTD_BIT_CHK_EN 0
`define DTD_BIT_CHK_CLR 1
`define DTD_BIT_CONST_EN 1
`define DTD_BIT_SHUF_MSB 2
`define DTD_BIT_SHUF_MID 1
`define DTD_BIT_SHUF_DDR 0
`define DTD_BIT_HALF_RATE 5
`define DTD_BIT_SYNC_OFF 1
`define DTD_CHK_CTRL_WMASK 8'h1f
`define DTD_CDR_RATE_WMASK 8'hff
`define DTD_MISC_PD_WMASK 8'h03
`define DTD_DIGITAL_TEST_CTRL_WMASK 8'h03

`endif

// ### core/dtd_pkg.sv
package dtd_pkg;
  typedef enum logic [1:0] {
    DTD_ZONE_FIRST = 2'h0,
    DTD_ZONE_SECOND = 2'h1,
    DTD_ZONE_RSVD2 = 2'h2,
    DTD_ZONE_RSVD3 = 2'h3
  } dtd_zone_t;
  typedef enum logic [1:0] {
    DTD_DIV_1 = 2'h0,
    DTD_DIV_2 = 2'h1,
    DTD_DIV_4 = 2'h2,
    DTD_DIV_RSVD = 2'h3
  } dtd_div_t;
endpackage : dtd_pkg

// ### core/dtd_err_counter.sv
`timescale 1ns/100ps
module dtd_err_counter #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic i_clear,
  input wire logic i_error,
  output logic [WIDTH-1:0] o_count
);
  if (WIDTH < 1) begin : g_width_chk
    $error("dtd_err_counter: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      count_reg <= '0; // RULE_01
    end else if (i_clear) begin
      count_reg <= '0; // RULE_16
    end else if (i_enable && i_error && (count_reg != {WIDTH{1'b1}})) begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1}; // RULE_18
    end
  end

  assign o_count = count_reg;
endmodule : dtd_err_counter

// ### core/dtd_sample_mux.sv
`timescale 1ns/100ps
module dtd_sample_mux #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_const_en,
  input wire logic [WIDTH-1:0] i_const_word,
  input wire logic [WIDTH-1:0] i_sample,
  output logic [WIDTH-1:0] o_sample
);
  if (WIDTH < 2) begin : g_width_chk
    $error("dtd_sample_mux: WIDTH must be at least 2");
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_sample <= '0;
    end else begin
      o_sample <= i_const_en ? i_const_word : i_sample; // RULE_03
    end
  end
endmodule : dtd_sample_mux

// ### verif/dtd_cfg_regs_checker.sv
`timescale 1ns/100ps
module dtd_cfg_regs_checker
  import dtd_pkg::*;
#(
  parameter int LANES = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic o_rvalid,
  input wire logic o_shuffle_msb,
  input wire logic o_middle_segment_shuffle,
  input wire logic o_shuffle_ddr,
  input wire logic [1:0] o_zone,
  input wire logic [1:0] o_port_slew,
  input wire logic [1:0] o_port_strength,
  input wire logic o_rx_analog_master_off,
  input wire logic [LANES-1:0] o_rx_lane_off,
  input wire logic o_clock_recovery_logic_reset,
  input wire logic o_half_rate_recovery_enable,
  input wire logic [1:0] o_division_rate
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  sequence s_wr(logic [9:0] a);
    i_wr_en && i_addr == a;
  endsequence
  property p_rvalid;
    o_rvalid == $past(i_rd_en);
  endproperty
  property p_shuffle;
    logic [7:0] d;
    (s_wr(10'h151), d = i_wdata) |-> ##2
      {o_shuffle_msb, o_middle_segment_shuffle, o_shuffle_ddr} == d[2:0];
  endproperty
  property p_zone;
    logic [7:0] d;
    (s_wr(10'h152), d = i_wdata) |-> ##2 o_zone == d[1:0];
  endproperty
  property p_drive;
    logic [7:0] d;
    (s_wr(10'h1df), d = i_wdata) |-> ##2 {o_port_strength, o_port_slew} == d[3:0];
  endproperty
  property p_master;
    logic [7:0] d;
    (s_wr(10'h200), d = i_wdata) |-> ##2 o_rx_analog_master_off == d[0];
  endproperty
  property p_lane;
    logic [7:0] d;
    (s_wr(10'h201), d = i_wdata) |-> ##2
      o_rx_lane_off == (d | {LANES{o_rx_analog_master_off}});
  endproperty
  property p_cdr_rst;
    logic [7:0] d;
    (s_wr(10'h206), d = i_wdata) |-> ##2 o_clock_recovery_logic_reset == d[0];
  endproperty
  property p_rate;
    logic [7:0] d;
    (s_wr(10'h230), d = i_wdata) |-> ##2
      o_half_rate_recovery_enable == d[5] && o_division_rate == d[2:1];
  endproperty
  property p_reset;
    disable iff (1'b0)
    !i_reset_n |=> o_rx_analog_master_off && o_clock_recovery_logic_reset &&
      o_half_rate_recovery_enable && {o_port_strength, o_port_slew} == 4'hf;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
  a_shuffle: assert property (p_shuffle) else $error("shuffle bits wrong");
  a_zone: assert property (p_zone) else $error("zone code wrong");
  a_drive: assert property (p_drive) else $error("drive field wrong");
  a_master: assert property (p_master) else $error("master off wrong");
  a_lane: assert property (p_lane) else $error("lane off wrong");
  a_cdr_rst: assert property (p_cdr_rst) else $error("recovery reset wrong");
  a_rate: assert property (p_rate) else $error("rate config wrong");
  a_reset: assert property (p_reset) else $error("reset outputs wrong");
endmodule : dtd_cfg_regs_checker

bind dtd_cfg_regs dtd_cfg_regs_checker #(.LANES(LANES)) u_dtd_cfg_regs_checker (
  .i_clk_sys, .i_reset_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rvalid,
  .o_shuffle_msb, .o_middle_segment_shuffle, .o_shuffle_ddr, .o_zone, .o_port_slew,
  .o_port_strength, .o_rx_analog_master_off, .o_rx_lane_off,
  .o_clock_recovery_logic_reset, .o_half_rate_recovery_enable, .o_division_rate
);

// ### verif/dtd_cfg_regs_tb.sv
`timescale 1ns/100ps
module dtd_cfg_regs_tb
  import dtd_pkg::*;
;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic i_clk_sys = 0, i_reset_n = 0, i_wr_en = 0, i_rd_en = 0;
  logic i_err_real = 0, i_err_imag = 0;
  logic [9:0] i_addr = '0;
  logic [7:0] i_wdata = '0, o_rdata, o_rx_lane_off;
  logic [15:0] i_sample = '0, o_sample;
  logic o_rvalid, o_checker_enable, o_checker_poly_long, o_checker_inv_real;
  logic o_checker_inv_imag, o_shuffle_msb, o_middle_segment_shuffle, o_shuffle_ddr;
  logic o_rx_analog_master_off, o_sync_request_buffer_off;
  logic o_clock_recovery_logic_reset, o_half_rate_recovery_enable;
  logic [1:0] o_port_slew, o_port_strength;
  dtd_zone_t o_zone;
  dtd_div_t o_division_rate;
  int error_cnt = 0, n_tests = 0;
  localparam logic [9:0] AD [14] = '{10'h14b, 10'h14c, 10'h14d, 10'h14e, 10'h14f,
    10'h150, 10'h151, 10'h152, 10'h1df, 10'h200, 10'h201, 10'h203, 10'h206, 10'h230};
  localparam logic [7:0] RV [14] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h0f, 8'h01, 8'h00, 8'h00, 8'h01, 8'h28};
  localparam logic [7:0] WM [14] = '{8'h1f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h03, 8'hff,
    8'h03, 8'h0f, 8'h01, 8'hff, 8'h03, 8'h01, 8'hff};

  dtd_cfg_regs u_dtd_cfg_regs (.*);

  always #4 i_clk_sys = ~i_clk_sys;

  function automatic logic [7:0] exp_rb(input int i, input logic [7:0] d);
    return d & WM[i];
  endfunction : exp_rb

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic st;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : st

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr_en <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr_en <= 0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd_en <= 1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 0;
    @(negedge i_clk_sys);
    chk("rvalid", 16'h1, 16'(o_rvalid));
    chk($sformatf("rdata %h", a), 16'(e), 16'(o_rdata));
  endtask : rd

  task automatic errs(input int n, input int m);
    @(posedge i_clk_sys);
    i_err_real <= 1;
    i_err_imag <= 1;
    repeat (n) @(posedge i_clk_sys);
    i_err_real <= 0;
    repeat (m) @(posedge i_clk_sys);
    i_err_imag <= 0;
    st;
  endtask : errs

  task automatic end_of_test;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin
    #(40000 * 8);
    error_cnt++;
    end_of_test();
  end

  initial begin
    int n;
    logic [15:0] w, s;
    logic [7:0] d;
    void'($urandom(32'hff01c2db));
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1;
    foreach (AD[i]) rd(AD[i], RV[i]);
    for (int k = 0; k < 4; k++) begin
      foreach (AD[i]) begin
        d = (k == 3) ? 8'hff : 8'($urandom);
        wr(AD[i], d);
        rd(AD[i], exp_rb(i, d));
      end
    end
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00);
    $display("register access done");
    for (int k = 0; k < 8; k++) begin
      wr(10'h151, 8'(k));
      wr(10'h152, 8'(k));
      wr(10'h230, 8'(k << 1));
      st;
      chk("shuffle msb", 16'(k[2]), 16'(o_shuffle_msb));
      chk("shuffle mid", 16'(k[1]), 16'(o_middle_segment_shuffle));
      chk("shuffle ddr", 16'(k[0]), 16'(o_shuffle_ddr));
      chk("zone", 16'(k[1:0]), 16'(o_zone));
      chk("division", 16'(k[1:0]), 16'(o_division_rate));
      chk("half rate", 16'h0, 16'(o_half_rate_recovery_enable));
    end
    d = 8'($urandom);
    wr(10'h1df, d);
    wr(10'h206, 8'h00);
    st;
    chk("drive", 16'(d[3:0]), {12'h0, o_port_strength, o_port_slew});
    chk("recovery reset", 16'h0, 16'(o_clock_recovery_logic_reset));
    wr(10'h200, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(10'h201, 8'h01 << k);
      st;
      chk("lane off", 16'(8'h01 << k), 16'(o_rx_lane_off));
    end
    wr(10'h200, 8'h01);
    st;
    chk("master off", 16'h01ff, {7'h0, o_rx_analog_master_off, o_rx_lane_off});
    d = 8'($urandom);
    wr(10'h14b, d);
    wr(10'h203, d);
    st;
    chk("checker enable", 16'(d[0]), 16'(o_checker_enable));
    chk("poly long", 16'(d[2]), 16'(o_checker_poly_long));
    chk("inv real", 16'(d[3]), 16'(o_checker_inv_real));
    chk("inv imag", 16'(d[4]), 16'(o_checker_inv_imag));
    chk("sync buffer off", 16'(d[1]), 16'(o_sync_request_buffer_off));
    $display("output fields done");
    n = $urandom_range(40, 1);
    wr(10'h14b, 8'h01);
    st;
    errs(n, 3);
    rd(10'h14c, 8'(n));
    rd(10'h14d, 8'(n + 3));
    wr(10'h14b, 8'h00);
    st;
    errs(4, 1);
    rd(10'h14c, 8'(n));
    wr(10'h14b, 8'h01);
    st;
    errs(300, 1);
    rd(10'h14c, 8'hff);
    wr(10'h14b, 8'h03);
    st;
    rd(10'h14c, 8'h00);
    rd(10'h14d, 8'h00);
    $display("error counters done");
    w = 16'($urandom);
    s = 16'($urandom);
    @(posedge i_clk_sys);
    i_sample <= s;
    wr(10'h14e, w[15:8]);
    wr(10'h14f, w[7:0]);
    wr(10'h150, 8'h02);
    st;
    chk("constant", w, o_sample);
    wr(10'h150, 8'h00);
    st;
    chk("sample", s, o_sample);
    $display("constant word done");
    end_of_test();
  end
endmodule : dtd_cfg_regs_tb
